// file: bridge_map.svh
// offsets-free constant map: timing counts, sizes and thresholds
`ifndef BRIDGE_MAP_SVH
`define BRIDGE_MAP_SVH
`define SYS_HZ 64'd50000000
`define XTAL_HZ 64'd3579545
`define BUS_BPS 64'd9600
`define BIT_TICKS ((`XTAL_HZ + `BUS_BPS / 64'd2) / `BUS_BPS)
`define GIVEUP_MS 64'd2000
`define GIVEUP_TICKS ((`XTAL_HZ * `GIVEUP_MS) / 64'd1000)
`define ST_UNIT_MS 64'd4
`define ST_UNIT_TICKS ((`XTAL_HZ * `ST_UNIT_MS) / 64'd1000)
`define GAP_BITS 16'h000A
`define PRIO_STEP_BITS 16'h0002
`define MIN_ACCESS_BITS 16'h000C
`define TX_MAX_DATA 5'h15
`define RX_MAX 6'h20
`define HOST_DEPTH 32
`endif

// file: bridge_pkg.sv
// shared types for the vehicle bus bridge
package bridge_pkg;
  typedef enum logic [3:0] {ALERT_NONE, ALERT_BUFFER_FULL, ALERT_BUS_BUSY,
    ALERT_DATA_ERROR, ALERT_NO_DATA, ALERT_PROT_ERROR, ALERT_RX_ERROR,
    ALERT_STOP, ALERT_UNKNOWN} alert_t;
  typedef struct packed {
    logic checksum_display_on;
    logic byte_spacing_off;
    logic error_report_off;
    logic relaxed_timing_check;
  } host_cfg_t;
  typedef struct packed {
    logic enable;
    logic [4:0] pos;
    logic [7:0] value;
  } filter_t;
  typedef struct packed {
    logic [7:0] data;
    logic space_before;
    logic last;
  } host_out_t;
  typedef enum logic [2:0] {TX_IDLE, TX_ACCESS, TX_SEND, TX_RESP} tx_state_t;
  typedef enum logic {CP_IDLE, CP_COPY} copy_state_t;
  typedef enum logic {RX_IDLE, RX_BITS} rx_state_t;
  typedef enum logic {UT_IDLE, UT_SHIFT} ut_state_t;
endpackage

// file: bus_bridge.sv
// vehicle bus bridge: framing, arbitration, receive checks, host alerts
`timescale 1ns/1ps
`include "bridge_map.svh"
module bus_bridge
#(
  parameter int unsigned BIT_TICKS = 32'(`BIT_TICKS),
  parameter int unsigned GIVEUP_TICKS = 32'(`GIVEUP_TICKS),
  parameter int unsigned ST_UNIT_TICKS = 32'(`ST_UNIT_TICKS),
  parameter int unsigned HOST_DEPTH = `HOST_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic bus_rx_pin,
  output logic bus_tx_pin,
  output logic bus_drive_en,
  input wire bridge_pkg::host_cfg_t cfg,
  input wire bridge_pkg::filter_t filter_a,
  input wire bridge_pkg::filter_t filter_b,
  input wire logic [7:0] source_id,
  input wire logic [3:0] priority_level,
  input wire logic [3:0] resp_count,
  input wire logic [7:0] response_timeout_setting,
  input wire logic pay_valid,
  input wire logic [7:0] pay_byte,
  input wire logic send_go,
  input wire logic host_char_in,
  input wire logic cmd_bad,
  output bridge_pkg::host_out_t host_out,
  output logic host_out_valid,
  input wire logic host_out_ready,
  output bridge_pkg::alert_t alert_code,
  output logic alert_valid,
  output logic busy,
  output logic [15:0] idle_bits
);
  localparam int AW = $clog2(HOST_DEPTH);
  localparam int SW = $clog2(BIT_TICKS + 1);
  localparam int GW = $clog2(GIVEUP_TICKS + 1);
  localparam int TW = $clog2(ST_UNIT_TICKS + 1);
  function automatic logic filt_hit(bridge_pkg::filter_t f, logic [7:0] b,
    logic [5:0] limit);
    filt_hit = f.enable && {1'b0, f.pos} < limit && b == f.value;
  endfunction
  logic [26:0] acc_q, acc_d;
  logic tick_q, tick_d;
  always_comb
  begin
    acc_d = acc_q + 27'(`XTAL_HZ);
    tick_d = 1'b0;
    if (acc_d >= 27'(`SYS_HZ))
    begin
      acc_d = acc_d - 27'(`SYS_HZ);
      tick_d = 1'b1;
    end
  end
  logic rx_meta_q, rx_s_q;
  logic ut_busy, ut_done, ut_coll, rx_active, rx_valid, rx_err;
  logic [7:0] rx_byte;
  logic ut_start_q, ut_start_d, ut_abort;
  logic [7:0] ut_byte;
  bus_uart #(.BIT_TICKS(BIT_TICKS)) u_uart (
    .clk_sys(clk_sys), .reset_n(reset_n), .tick(tick_q), .rx_s(rx_s_q),
    .tx_start(ut_start_q), .tx_byte(ut_byte), .tx_abort(ut_abort),
    .tx_busy(ut_busy), .tx_done(ut_done), .collision(ut_coll),
    .rx_active(rx_active), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_err(rx_err), .bus_tx(bus_tx_pin), .bus_drive_en(bus_drive_en));
  logic [SW-1:0] sub_q, sub_d;
  logic [15:0] idle_d, gap_q, gap_d;
  logic act_q;
  always_comb
  begin
    sub_d = sub_q;
    idle_d = idle_bits;
    gap_d = gap_q;
    if (rx_active || ut_busy)
    begin
      sub_d = '0;
      idle_d = 16'h0000;
      if (rx_active && !act_q)
        gap_d = idle_bits;
    end
    else if (tick_q)
    begin
      if (sub_q == SW'(BIT_TICKS - 1))
      begin
        sub_d = '0;
        if (idle_bits != 16'hFFFF)
          idle_d = idle_bits + 16'h0001;
      end
      else
        sub_d = sub_q + SW'(1);
    end
  end
  // receive message assembly
  logic [7:0] rx_mem_q [0:31];
  logic [7:0] rx_mem_d [0:31];
  logic [5:0] len_q, len_d, eval_len;
  logic [7:0] sum_q, sum_d;
  logic bad_q, bad_d, prot_q, prot_d, own_q, own_d;
  logic msg_end, pass, deliver;
  assign msg_end = len_q != 6'h00 && !rx_active && idle_bits >= `GAP_BITS;
  assign eval_len = cfg.checksum_display_on ? len_q : len_q - 6'h01;
  assign pass = (!filter_a.enable && !filter_b.enable)
    || filt_hit(filter_a, rx_mem_q[filter_a.pos], eval_len)
    || filt_hit(filter_b, rx_mem_q[filter_b.pos], eval_len);
  assign deliver = msg_end && !own_q && !bad_q && pass;
  always_comb
  begin
    rx_mem_d = rx_mem_q;
    len_d = len_q;
    sum_d = sum_q;
    bad_d = bad_q;
    prot_d = prot_q;
    own_d = own_q;
    if (msg_end)
    begin
      len_d = 6'h00;
      sum_d = 8'h00;
      bad_d = 1'b0;
      prot_d = 1'b0;
      own_d = 1'b0;
    end
    else if ((rx_valid || rx_err) && len_q < `RX_MAX)
    begin
      if (len_q == 6'h00)
        prot_d = !cfg.relaxed_timing_check && gap_q < `MIN_ACCESS_BITS;
      if (ut_busy)
        own_d = 1'b1;
      if (rx_err)
        bad_d = 1'b1;
      rx_mem_d[len_q[4:0]] = rx_byte;
      sum_d = sum_q + rx_byte;
      len_d = len_q + 6'h01;
    end
  end
  bridge_pkg::host_out_t fifo_q [0:HOST_DEPTH-1];
  bridge_pkg::host_out_t fifo_d [0:HOST_DEPTH-1];
  bridge_pkg::host_out_t out_d;
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic full, push, pop, outv_d;
  bridge_pkg::copy_state_t cp_q, cp_d;
  logic [5:0] cp_idx_q, cp_idx_d, cp_len_q, cp_len_d;
  logic ovf_d;
  assign full = (wr_q - rd_q) == (AW + 1)'(HOST_DEPTH);
  assign push = cp_q == bridge_pkg::CP_COPY && !full;
  assign pop = wr_q != rd_q && (!host_out_valid || host_out_ready);
  always_comb
  begin
    fifo_d = fifo_q;
    wr_d = wr_q;
    rd_d = rd_q;
    out_d = host_out;
    outv_d = host_out_valid && !host_out_ready;
    cp_d = cp_q;
    cp_idx_d = cp_idx_q;
    cp_len_d = cp_len_q;
    ovf_d = 1'b0;
    if (cp_q == bridge_pkg::CP_IDLE && deliver && eval_len != 6'h00)
    begin
      cp_d = bridge_pkg::CP_COPY;
      cp_idx_d = 6'h00;
      cp_len_d = eval_len;
    end
    if (cp_q == bridge_pkg::CP_COPY)
    begin
      if (push)
      begin
        fifo_d[wr_q[AW-1:0]].data = rx_mem_q[cp_idx_q[4:0]];
        fifo_d[wr_q[AW-1:0]].space_before =
          !cfg.byte_spacing_off && cp_idx_q != 6'h00;
        fifo_d[wr_q[AW-1:0]].last = cp_idx_q == cp_len_q - 6'h01;
        wr_d = wr_q + (AW + 1)'(1);
      end
      else
        ovf_d = 1'b1;
      cp_idx_d = cp_idx_q + 6'h01;
      if (cp_idx_q == cp_len_q - 6'h01)
        cp_d = bridge_pkg::CP_IDLE;
    end
    if (pop)
    begin
      out_d = fifo_q[rd_q[AW-1:0]];
      outv_d = 1'b1;
      rd_d = rd_q + (AW + 1)'(1);
    end
  end
  // transmit sequencer
  bridge_pkg::tx_state_t st_q, st_d;
  logic [7:0] pay_q [0:20];
  logic [7:0] pay_d [0:20];
  logic [4:0] pay_cnt_q, pay_cnt_d, idx_q, idx_d;
  logic [7:0] pay_sum_q, pay_sum_d, lfsr_q, lfsr_d;
  logic [2:0] extra_q, extra_d;
  logic [GW-1:0] give_q, give_d;
  logic [TW-1:0] stu_q, stu_d;
  logic [7:0] units_q, units_d;
  logic [3:0] left_q, left_d;
  logic got_q, got_d, ovf_seen_q, ovf_seen_d;
  logic [15:0] access_bits;
  bridge_pkg::alert_t alert_d;
  assign access_bits = `GAP_BITS + `PRIO_STEP_BITS * {12'h000, priority_level}
    + {13'h0000, extra_q};
  assign ut_abort = st_q != bridge_pkg::TX_IDLE && host_char_in;
  assign ut_byte = idx_q == 5'h00 ? source_id
    : idx_q <= pay_cnt_q ? pay_q[idx_q - 5'h01]
    : 8'(~(source_id + pay_sum_q) + 8'h01);
  always_comb
  begin
    st_d = st_q;
    pay_d = pay_q;
    pay_cnt_d = pay_cnt_q;
    pay_sum_d = pay_sum_q;
    idx_d = idx_q;
    extra_d = extra_q;
    give_d = give_q;
    stu_d = stu_q;
    units_d = units_q;
    left_d = left_q;
    got_d = got_q;
    ut_start_d = 1'b0;
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    alert_d = bridge_pkg::ALERT_NONE;
    ovf_seen_d = ovf_seen_q && !msg_end;
    if (tick_q && (st_q == bridge_pkg::TX_ACCESS
      || st_q == bridge_pkg::TX_SEND))
      give_d = give_q + GW'(1);
    case (st_q)
      bridge_pkg::TX_IDLE:
      begin
        if (pay_valid && pay_cnt_q < `TX_MAX_DATA)
        begin
          pay_d[pay_cnt_q] = pay_byte;
          pay_cnt_d = pay_cnt_q + 5'h01;
          pay_sum_d = pay_sum_q + pay_byte;
        end
        if (send_go)
        begin
          st_d = bridge_pkg::TX_ACCESS;
          give_d = '0;
          extra_d = 3'h0;
        end
      end
      bridge_pkg::TX_ACCESS:
      begin
        if (!rx_active && idle_bits >= access_bits)
        begin
          st_d = bridge_pkg::TX_SEND;
          idx_d = 5'h00;
          ut_start_d = 1'b1;
        end
      end
      bridge_pkg::TX_SEND:
      begin
        if (ut_coll)
        begin
          st_d = bridge_pkg::TX_ACCESS;
          extra_d = lfsr_q[2:0];
        end
        else if (ut_done && idx_q == pay_cnt_q + 5'h01)
        begin
          st_d = resp_count == 4'h0 ? bridge_pkg::TX_IDLE
            : bridge_pkg::TX_RESP;
          left_d = resp_count;
          got_d = 1'b0;
          stu_d = '0;
          units_d = 8'h00;
          pay_cnt_d = 5'h00;
          pay_sum_d = 8'h00;
        end
        else if (ut_done)
        begin
          idx_d = idx_q + 5'h01;
          ut_start_d = 1'b1;
        end
      end
      bridge_pkg::TX_RESP:
      begin
        if (deliver)
        begin
          got_d = 1'b1;
          stu_d = '0;
          units_d = 8'h00;
          left_d = left_q - 4'h1;
          if (left_q == 4'h1)
            st_d = bridge_pkg::TX_IDLE;
        end
        else if (tick_q && stu_q == TW'(ST_UNIT_TICKS - 1))
        begin
          stu_d = '0;
          units_d = units_q + 8'h01;
          if (units_q + 8'h01 >= response_timeout_setting)
          begin
            st_d = bridge_pkg::TX_IDLE;
            if (!got_q)
              alert_d = bridge_pkg::ALERT_NO_DATA;
          end
        end
        else if (tick_q)
          stu_d = stu_q + TW'(1);
      end
      default: st_d = bridge_pkg::TX_IDLE;
    endcase
    if (give_q >= GW'(GIVEUP_TICKS) && st_q != bridge_pkg::TX_IDLE
      && st_q != bridge_pkg::TX_RESP)
    begin
      st_d = bridge_pkg::TX_IDLE;
      pay_cnt_d = 5'h00;
      pay_sum_d = 8'h00;
      alert_d = bridge_pkg::ALERT_BUS_BUSY;
    end
    if (ut_abort)
    begin
      st_d = bridge_pkg::TX_IDLE;
      ut_start_d = 1'b0;
      pay_cnt_d = 5'h00;
      pay_sum_d = 8'h00;
      alert_d = bridge_pkg::ALERT_STOP;
    end
    else if (alert_d == bridge_pkg::ALERT_NONE)
    begin
      if (ovf_d && !ovf_seen_q)
      begin
        alert_d = bridge_pkg::ALERT_BUFFER_FULL;
        ovf_seen_d = 1'b1;
      end
      else if (msg_end && !own_q && !cfg.error_report_off)
      begin
        if (bad_q)
          alert_d = bridge_pkg::ALERT_RX_ERROR;
        else if (sum_q != 8'h00)
          alert_d = bridge_pkg::ALERT_DATA_ERROR;
        else if (prot_q)
          alert_d = bridge_pkg::ALERT_PROT_ERROR;
      end
      else if (cmd_bad)
        alert_d = bridge_pkg::ALERT_UNKNOWN;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    rx_meta_q <= bus_rx_pin;
    rx_s_q <= rx_meta_q;
    fifo_q <= fifo_d;
    rx_mem_q <= rx_mem_d;
    pay_q <= pay_d;
    if (!reset_n)
    begin
      acc_q <= '0;
      tick_q <= 1'b0;
      sub_q <= '0;
      idle_bits <= 16'h0000;
      gap_q <= 16'h0000;
      act_q <= 1'b0;
      len_q <= 6'h00;
      sum_q <= 8'h00;
      bad_q <= 1'b0;
      prot_q <= 1'b0;
      own_q <= 1'b0;
      wr_q <= '0;
      rd_q <= '0;
      host_out <= '0;
      host_out_valid <= 1'b0;
      cp_q <= bridge_pkg::CP_IDLE;
      cp_idx_q <= 6'h00;
      cp_len_q <= 6'h00;
      st_q <= bridge_pkg::TX_IDLE;
      pay_cnt_q <= 5'h00;
      pay_sum_q <= 8'h00;
      idx_q <= 5'h00;
      extra_q <= 3'h0;
      give_q <= '0;
      stu_q <= '0;
      units_q <= 8'h00;
      left_q <= 4'h0;
      got_q <= 1'b0;
      ovf_seen_q <= 1'b0;
      lfsr_q <= 8'h5A;
      ut_start_q <= 1'b0;
      alert_code <= bridge_pkg::ALERT_NONE;
      alert_valid <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tick_q <= tick_d;
      sub_q <= sub_d;
      idle_bits <= idle_d;
      gap_q <= gap_d;
      act_q <= rx_active;
      len_q <= len_d;
      sum_q <= sum_d;
      bad_q <= bad_d;
      prot_q <= prot_d;
      own_q <= own_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      host_out <= out_d;
      host_out_valid <= outv_d;
      cp_q <= cp_d;
      cp_idx_q <= cp_idx_d;
      cp_len_q <= cp_len_d;
      st_q <= st_d;
      pay_cnt_q <= pay_cnt_d;
      pay_sum_q <= pay_sum_d;
      idx_q <= idx_d;
      extra_q <= extra_d;
      give_q <= give_d;
      stu_q <= stu_d;
      units_q <= units_d;
      left_q <= left_d;
      got_q <= got_d;
      ovf_seen_q <= ovf_seen_d;
      lfsr_q <= lfsr_d;
      ut_start_q <= ut_start_d;
      alert_code <= alert_d;
      alert_valid <= alert_d != bridge_pkg::ALERT_NONE;
      busy <= st_d != bridge_pkg::TX_IDLE;
    end
  end
endmodule

// file: bus_bridge_bench.sv
// self-checking bench for the vehicle bus bridge
`timescale 1ns/1ps
module bus_bridge_bench;
  localparam realtime BIT_NS = 12 * 1.0e9 / 3579545.0;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic bus_rx_pin, bus_tx_pin, bus_drive_en, host_out_valid, alert_valid, busy;
  logic pay_valid = 1'b0, send_go = 1'b0, host_char_in = 1'b0;
  logic cmd_bad = 1'b0, host_out_ready = 1'b0;
  logic [7:0] pay_byte = 8'h00, tmo = 8'h01;
  logic [3:0] resp_count = 4'h0, prio = 4'h1;
  logic [15:0] idle_bits;
  bridge_pkg::host_cfg_t cfg = '0;
  bridge_pkg::filter_t filter_a = '0, filter_b = '0;
  bridge_pkg::host_out_t host_out;
  bridge_pkg::alert_t alert_code, last_alert;
  bridge_pkg::host_out_t outq [$];
  int n_errors = 0, checks_done = 0, n_alerts = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) host_out_ready <= #1 ~host_out_ready;
  bus_bridge #(.BIT_TICKS(12), .GIVEUP_TICKS(1200), .ST_UNIT_TICKS(50))
    dut (.clk_sys, .reset_n, .bus_rx_pin, .bus_tx_pin,
    .bus_drive_en, .cfg, .filter_a, .filter_b, .source_id(8'h80),
    .priority_level(prio), .resp_count, .response_timeout_setting(tmo),
    .pay_valid, .pay_byte, .send_go, .host_char_in, .cmd_bad, .host_out,
    .host_out_valid, .host_out_ready, .alert_code, .alert_valid, .busy,
    .idle_bits);
  bus_node_model #(.BIT_NS(BIT_NS)) node (.dev_tx(bus_tx_pin),
    .dev_en(bus_drive_en), .line(bus_rx_pin));
  always @(posedge clk_sys)
  begin
    if (alert_valid === 1'b1)
    begin
      last_alert = alert_code;
      n_alerts++;
    end
    if (host_out_valid === 1'b1 && host_out_ready === 1'b1)
      outq.push_back(host_out);
  end
  task automatic end_of_test();
    if (n_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic timeout();
    check(16'h0001, 16'h0000);
    end_of_test();
  endtask
  task automatic expect_alert(input bridge_pkg::alert_t want, input int lim);
    int base;
    base = n_alerts;
    for (int i = 0; i < lim && n_alerts == base; i++)
      cyc(1);
    if (n_alerts == base)
      timeout();
    check(16'(last_alert), 16'(want));
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 9000 && outq.size() < n; i++)
      cyc(1);
    check(16'(outq.size()), 16'(n));
  endtask
  task automatic start(input logic [7:0] b);
    pay_byte = b;
    pay_valid = 1'b1;
    cyc(1);
    pay_valid = 1'b0;
    send_go = 1'b1;
    cyc(1);
    send_go = 1'b0;
  endtask
  task automatic t_send();
    logic [7:0] m [3] = '{8'h80, 8'h12, 8'hF0};
    logic [7:0] b, sum;
    int i;
    pay_byte = m[1];
    pay_valid = 1'b1;
    cyc(1);
    start(m[2]);
    sum = 8'h00;
    for (int k = 0; k < 4; k++)
    begin
      for (i = 0; i < 40000 && !(bus_drive_en && !bus_tx_pin); i++)
        #20;
      if (i == 40000)
        timeout();
      #(BIT_NS * 1.5);
      for (int j = 0; j < 8; j++)
      begin
        b[j] = bus_tx_pin;
        #(BIT_NS);
      end
      check(16'(b), 16'(k < 3 ? m[k] : 8'(8'h00 - sum)));
      sum += (k < 3) ? m[k] : 8'h00;
    end
    cyc(1);
    for (i = 0; i < 3000 && busy !== 1'b0; i++)
      cyc(1);
    check(16'(busy), 16'h0000);
  endtask
  task automatic t_rx(input logic [7:0] cs, input int n);
    logic [7:0] m [3] = '{8'h8C, 8'h01, cs};
    outq.delete();
    foreach (m[i]) node.send_byte(m[i], 1'b1);
    if (n == 0)
      cyc(2000);
    wait_q(n);
    for (int i = 0; i < outq.size(); i++)
      check(16'(outq[i]), 16'({m[i], i != 0, i == outq.size() - 1}));
  endtask
  initial
  begin
    cyc(10);
    check(16'({alert_code, bus_tx_pin, bus_drive_en, host_out_valid,
      alert_valid, busy}), 16'h0010);
    check(idle_bits, 16'h0000);
    reset_n = 1'b1;
    cyc(1);
    cmd_bad = 1'b1;
    cyc(1);
    cmd_bad = 1'b0;
    expect_alert(bridge_pkg::ALERT_UNKNOWN, 4);
    t_send();
    cyc(2200);
    cfg.checksum_display_on = 1'b1;
    filter_a = '{1'b1, 5'h02, 8'h73};
    t_rx(8'h73, 3);
    t_rx(8'h74, 0);
    filter_a.enable = 1'b0;
    cfg.checksum_display_on = 1'b0;
    cyc(2000);
    fork
      t_rx(8'h74, 2);
      expect_alert(bridge_pkg::ALERT_DATA_ERROR, 9000);
    join
    fork
      t_rx(8'h73, 2);
      expect_alert(bridge_pkg::ALERT_PROT_ERROR, 9000);
    join
    cyc(3000);
    node.send_byte(8'h55, 1'b0);
    expect_alert(bridge_pkg::ALERT_RX_ERROR, 9000);
    resp_count = 4'h1;
    start(8'h3C);
    expect_alert(bridge_pkg::ALERT_NO_DATA, 20000);
    resp_count = 4'h0;
    cyc(3000);
    start(8'h3C);
    cyc(50);
    host_char_in = 1'b1;
    cyc(1);
    host_char_in = 1'b0;
    expect_alert(bridge_pkg::ALERT_STOP, 4);
    cfg.error_report_off = 1'b1;
    fork
      node.hold_low(BIT_NS * 200);
    join_none
    start(8'h3C);
    expect_alert(bridge_pkg::ALERT_BUS_BUSY, 40000);
    end_of_test();
  end
endmodule

// file: bus_bridge_checker.sv
// port assertions for the bus bridge
`timescale 1ns/1ps
module bus_bridge_checker
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic bus_tx_pin,
  input wire logic bus_drive_en,
  input wire bridge_pkg::host_cfg_t cfg,
  input wire logic [3:0] priority_level,
  input wire logic send_go,
  input wire logic host_char_in,
  input wire logic cmd_bad,
  input wire bridge_pkg::host_out_t host_out,
  input wire logic host_out_valid,
  input wire logic host_out_ready,
  input wire bridge_pkg::alert_t alert_code,
  input wire logic alert_valid,
  input wire logic busy,
  input wire logic [15:0] idle_bits
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // cycles the line has been released, to tell a new access from a byte gap
  logic [3:0] low_q;
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n || bus_drive_en)
      low_q <= 4'h0;
    else if (low_q != 4'hF)
      low_q <= low_q + 4'h1;
  end
  sequence s_stop;
    ##1 alert_valid && alert_code == bridge_pkg::ALERT_STOP;
  endsequence
  sequence s_quit;
    ##[1:4] !busy;
  endsequence
  property p_stop;
    host_char_in && busy |-> s_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop alert");
  property p_quit;
    host_char_in && busy |-> s_quit;
  endproperty
  a_quit: assert property (p_quit) else $error("abort kept busy");
  property p_bad;
    cmd_bad && !busy && !host_char_in |-> ##1 alert_valid;
  endproperty
  a_bad: assert property (p_bad) else $error("no bad cmd alert");
  property p_go;
    send_go && !busy && !host_char_in |=> busy;
  endproperty
  a_go: assert property (p_go) else $error("send not taken");
  property p_rel;
    !bus_drive_en |-> bus_tx_pin;
  endproperty
  a_rel: assert property (p_rel) else $error("line not released");
  property p_wait;
    $rose(bus_drive_en) && low_q > 4'h4 |->
      $past(idle_bits) >= 16'd10 + {11'h000, priority_level, 1'b0};
  endproperty
  a_wait: assert property (p_wait) else $error("access too early");
  property p_hold;
    host_out_valid && !host_out_ready |=> host_out_valid && $stable(host_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output lost");
  property p_mute;
    alert_valid && cfg.error_report_off |-> !(alert_code inside
      {bridge_pkg::ALERT_RX_ERROR, bridge_pkg::ALERT_DATA_ERROR,
      bridge_pkg::ALERT_PROT_ERROR});
  endproperty
  a_mute: assert property (p_mute) else $error("muted alert shown");
  property p_count;
    idle_bits != $past(idle_bits) |->
      idle_bits == 16'h0000 || idle_bits == $past(idle_bits) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("idle count jump");
  property p_busy;
    alert_valid && alert_code == bridge_pkg::ALERT_BUS_BUSY |-> ##[0:3] !busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy after give-up");
endmodule
bind bus_bridge bus_bridge_checker chk (.clk_sys, .reset_n, .bus_tx_pin,
  .bus_drive_en, .cfg, .priority_level, .send_go, .host_char_in, .cmd_bad,
  .host_out, .host_out_valid, .host_out_ready, .alert_code, .alert_valid,
  .busy, .idle_bits);

// file: bus_node_model.sv
// far bus node: frames bytes onto the shared bus line
`timescale 1ns/1ps
module bus_node_model
#(
  parameter realtime BIT_NS = 3352.0
)
(
  input wire logic dev_tx,
  input wire logic dev_en,
  output logic line
);
  logic drv = 1'b1;
  // wired bus, pull-up when nobody drives
  assign line = drv & (dev_en ? dev_tx : 1'b1);
  task automatic send_byte(input logic [7:0] b, input logic stop_ok);
    drv = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++)
    begin
      drv = b[i];
      #(BIT_NS);
    end
    drv = stop_ok;
    #(BIT_NS);
    drv = 1'b1;
  endtask
  task automatic hold_low(input realtime t);
    drv = 1'b0;
    #(t);
    drv = 1'b1;
  endtask
endmodule

// file: bus_uart.sv
// bus byte serialiser with framing check and collision detect
`timescale 1ns/1ps
module bus_uart
#(
  parameter int unsigned BIT_TICKS = 373
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic rx_s,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  input wire logic tx_abort,
  output logic tx_busy,
  output logic tx_done,
  output logic collision,
  output logic rx_active,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_err,
  output logic bus_tx,
  output logic bus_drive_en
);
  localparam int CW = $clog2(BIT_TICKS + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_TICKS - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_TICKS / 2);
  bridge_pkg::rx_state_t rx_st_q, rx_st_d;
  bridge_pkg::ut_state_t ut_st_q, ut_st_d;
  logic rx_prev_q;
  logic [CW-1:0] rx_cnt_q, rx_cnt_d, ut_cnt_q, ut_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d, ut_bit_q, ut_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d;
  logic [9:0] ut_sh_q, ut_sh_d;
  logic valid_d, err_d, done_d, coll_d, tx_d, drv_d;
  assign rx_active = (rx_st_q == bridge_pkg::RX_BITS);
  assign tx_busy = (ut_st_q == bridge_pkg::UT_SHIFT);
  assign rx_byte = rx_sh_q;
  always_comb
  begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    valid_d = 1'b0;
    err_d = 1'b0;
    case (rx_st_q)
      bridge_pkg::RX_IDLE:
      begin
        if (rx_prev_q && !rx_s)
        begin
          rx_st_d = bridge_pkg::RX_BITS;
          rx_cnt_d = HALF;
          rx_bit_d = 4'h0;
        end
      end
      bridge_pkg::RX_BITS:
      begin
        if (tick && rx_cnt_q == '0)
        begin
          rx_cnt_d = FULL;
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'h0 && rx_s)
          begin
            err_d = 1'b1;
            rx_st_d = bridge_pkg::RX_IDLE;
          end
          else if (rx_bit_q == 4'h9)
          begin
            valid_d = rx_s;
            err_d = !rx_s;
            rx_st_d = bridge_pkg::RX_IDLE;
          end
          else if (rx_bit_q != 4'h0)
            rx_sh_d = {rx_s, rx_sh_q[7:1]};
        end
        else if (tick)
          rx_cnt_d = rx_cnt_q - CW'(1);
      end
      default: rx_st_d = bridge_pkg::RX_IDLE;
    endcase
  end
  always_comb
  begin
    ut_st_d = ut_st_q;
    ut_cnt_d = ut_cnt_q;
    ut_bit_d = ut_bit_q;
    ut_sh_d = ut_sh_q;
    done_d = 1'b0;
    coll_d = 1'b0;
    case (ut_st_q)
      bridge_pkg::UT_IDLE:
      begin
        if (tx_start)
        begin
          ut_st_d = bridge_pkg::UT_SHIFT;
          ut_sh_d = {1'b1, tx_byte, 1'b0};
          ut_cnt_d = FULL;
          ut_bit_d = 4'h0;
        end
      end
      bridge_pkg::UT_SHIFT:
      begin
        if (tx_abort)
          ut_st_d = bridge_pkg::UT_IDLE;
        else if (tick && ut_cnt_q == HALF && rx_s != ut_sh_q[0])
        begin
          coll_d = 1'b1;
          ut_st_d = bridge_pkg::UT_IDLE;
        end
        else if (tick && ut_cnt_q == '0)
        begin
          ut_cnt_d = FULL;
          if (ut_bit_q == 4'h9)
          begin
            done_d = 1'b1;
            ut_st_d = bridge_pkg::UT_IDLE;
          end
          else
          begin
            ut_sh_d = {1'b1, ut_sh_q[9:1]};
            ut_bit_d = ut_bit_q + 4'h1;
          end
        end
        else if (tick)
          ut_cnt_d = ut_cnt_q - CW'(1);
      end
      default: ut_st_d = bridge_pkg::UT_IDLE;
    endcase
    drv_d = (ut_st_d == bridge_pkg::UT_SHIFT);
    tx_d = drv_d ? ut_sh_d[0] : 1'b1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      rx_st_q <= bridge_pkg::RX_IDLE;
      ut_st_q <= bridge_pkg::UT_IDLE;
      rx_prev_q <= 1'b1;
      rx_cnt_q <= '0;
      ut_cnt_q <= '0;
      rx_bit_q <= 4'h0;
      ut_bit_q <= 4'h0;
      rx_sh_q <= 8'h00;
      ut_sh_q <= 10'h3FF;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      tx_done <= 1'b0;
      collision <= 1'b0;
      bus_tx <= 1'b1;
      bus_drive_en <= 1'b0;
    end
    else
    begin
      rx_st_q <= rx_st_d;
      ut_st_q <= ut_st_d;
      rx_prev_q <= rx_s;
      rx_cnt_q <= rx_cnt_d;
      ut_cnt_q <= ut_cnt_d;
      rx_bit_q <= rx_bit_d;
      ut_bit_q <= ut_bit_d;
      rx_sh_q <= rx_sh_d;
      ut_sh_q <= ut_sh_d;
      rx_valid <= valid_d;
      rx_err <= err_d;
      tx_done <= done_d;
      collision <= coll_d;
      bus_tx <= tx_d;
      bus_drive_en <= drv_d;
    end
  end
endmodule
